// >>> logic/ppi_pkg.sv
// Package of constants for the programmable parallel I/O port
package ppi_pkg;
    localparam int PPI_W = 8;
    localparam logic [1:0] PPI_SEL_FIRST = 2'h0;
    localparam logic [1:0] PPI_SEL_SECOND = 2'h1;
    localparam logic [1:0] PPI_SEL_THIRD = 2'h2;
    localparam logic [1:0] PPI_SEL_CFG = 2'h3;
    // Configuration word fields
    localparam int CFG_MODE_SET_BIT = 7;
    localparam int CFG_A_IN_BIT = 4;
    localparam int CFG_CU_IN_BIT = 3;
    localparam int CFG_B_IN_BIT = 1;
    localparam int CFG_CL_IN_BIT = 0;
    localparam int CFG_BSR_VAL_BIT = 0;
    localparam int CFG_BSR_SEL_LSB = 1;
    // Reset value: every port direction bit set, so all lines are inputs
    localparam logic [7:0] CFG_RESET = 8'h9b;
    localparam logic [7:0] PORT_RESET = 8'h00;
endpackage

// >>> logic/ppi_port.sv
// Three-port parallel I/O block with host strobe interface
`timescale 1ns/1ps
module ppi_port
    import ppi_pkg::*;
(
    input wire logic clk_i, // 250 MHz clock
    input wire logic sys_rst_i, // Synchronous reset, active high
    input wire logic sel_n_i, // Device select, active low
    input wire logic rd_n_i, // Read strobe, active low
    input wire logic wr_n_i, // Write strobe, active low
    input wire logic [1:0] port_select_lines_i, // Target select
    input wire logic [PPI_W-1:0] host_data_bus_i, // Host bus level in
    output logic [PPI_W-1:0] host_data_bus_o, // Host bus drive value
    output logic host_data_bus_oe_o, // Host bus drive enable
    input wire logic [PPI_W-1:0] first_port_pins_i, // First port pin levels
    output logic [PPI_W-1:0] first_port_pins_o, // First port drive value
    output logic [PPI_W-1:0] first_port_pins_oe_o, // First port drive enables
    input wire logic [PPI_W-1:0] second_port_pins_i, // Second port pin levels
    output logic [PPI_W-1:0] second_port_pins_o, // Second port drive value
    output logic [PPI_W-1:0] second_port_pins_oe_o, // Second port drive enables
    input wire logic [PPI_W-1:0] third_port_pins_i, // Third port pin levels
    output logic [PPI_W-1:0] third_port_pins_o, // Third port drive value
    output logic [PPI_W-1:0] third_port_pins_oe_o // Third port drive enables
);
    import ppi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: all host and pin inputs are asynchronous
    logic sel_n_m, rd_n_m, wr_n_m;
    logic sel_n_s, rd_n_s, wr_n_s;
    logic [1:0] psel_m, psel_s;
    logic [PPI_W-1:0] hd_m, hd_s;
    logic [PPI_W-1:0] pa_m, pa_s, pb_m, pb_s, pc_m, pc_s;
    logic sel_n_d, wr_n_d;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sel_n_m <= 1'b1;
            sel_n_s <= 1'b1;
            rd_n_m <= 1'b1;
            rd_n_s <= 1'b1;
            wr_n_m <= 1'b1;
            wr_n_s <= 1'b1;
            sel_n_d <= 1'b1;
            wr_n_d <= 1'b1;
            psel_m <= 2'h0;
            psel_s <= 2'h0;
            hd_m <= PORT_RESET;
            hd_s <= PORT_RESET;
            pa_m <= PORT_RESET;
            pa_s <= PORT_RESET;
            pb_m <= PORT_RESET;
            pb_s <= PORT_RESET;
            pc_m <= PORT_RESET;
            pc_s <= PORT_RESET;
        end else begin
            sel_n_m <= sel_n_i;
            sel_n_s <= sel_n_m;
            rd_n_m <= rd_n_i;
            rd_n_s <= rd_n_m;
            wr_n_m <= wr_n_i;
            wr_n_s <= wr_n_m;
            sel_n_d <= sel_n_s;
            wr_n_d <= wr_n_s;
            psel_m <= port_select_lines_i;
            psel_s <= psel_m;
            hd_m <= host_data_bus_i;
            hd_s <= hd_m;
            pa_m <= first_port_pins_i;
            pa_s <= pa_m;
            pb_m <= second_port_pins_i;
            pb_s <= pb_m;
            pc_m <= third_port_pins_i;
            pc_s <= pc_m;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One-hot target decode shared by the write and read paths, so both
    // sides always agree on which register a select code reaches.
    function automatic logic [3:0] tgt_dec(input logic [1:0] sel);
        logic [3:0] hit;
        hit = 4'h8;
        if (sel == PPI_SEL_FIRST) begin
            hit = 4'h1;
        end else if (sel == PPI_SEL_SECOND) begin
            hit = 4'h2;
        end else if (sel == PPI_SEL_THIRD) begin
            hit = 4'h4;
        end
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Write capture on the rising write strobe; select must still be low.
    // Address and data are sampled one cycle after their synchronisers, matching the
    // strobe path so host setup is honoured at the same edge.
    logic wr_commit;
    assign wr_commit = !wr_n_d && wr_n_s && !sel_n_d;

    logic [7:0] cfg_r, cfg_nxt;
    logic [PPI_W-1:0] out_a_r, out_a_nxt, out_b_r, out_b_nxt, out_c_r, out_c_nxt;
    logic [PPI_W-1:0] in_a_r, in_a_nxt;
    logic [PPI_W-1:0] wdat_r;
    logic [1:0] wsel_r;
    logic [3:0] wr_hit;
    assign wr_hit = tgt_dec(wsel_r);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wdat_r <= PORT_RESET;
            wsel_r <= 2'h0;
        end else begin
            wdat_r <= hd_s;
            wsel_r <= psel_s;
        end
    end

    always_comb begin
        cfg_nxt = cfg_r;
        out_a_nxt = out_a_r;
        out_b_nxt = out_b_r;
        out_c_nxt = out_c_r;
        in_a_nxt = pa_s;
        if (wr_commit) begin
            if (wr_hit[0]) begin
                out_a_nxt = wdat_r;
            end else if (wr_hit[1]) begin
                out_b_nxt = wdat_r;
            end else if (wr_hit[2]) begin
                out_c_nxt = wdat_r;
            end else if (wdat_r[CFG_MODE_SET_BIT]) begin
                cfg_nxt = wdat_r;
                out_a_nxt = PORT_RESET;
                out_b_nxt = PORT_RESET;
                out_c_nxt = PORT_RESET;
            end else begin
                out_c_nxt[wdat_r[CFG_BSR_SEL_LSB +: 3]] = wdat_r[CFG_BSR_VAL_BIT];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg_r <= CFG_RESET;
            out_a_r <= PORT_RESET;
            out_b_r <= PORT_RESET;
            out_c_r <= PORT_RESET;
            in_a_r <= PORT_RESET;
        end else begin
            cfg_r <= cfg_nxt;
            out_a_r <= out_a_nxt;
            out_b_r <= out_b_nxt;
            out_c_r <= out_c_nxt;
            in_a_r <= in_a_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port directions per group; only the basic in/out mode is decoded
    logic a_in, cu_in, b_in, cl_in;
    assign a_in = cfg_r[CFG_A_IN_BIT];
    assign cu_in = cfg_r[CFG_CU_IN_BIT];
    assign b_in = cfg_r[CFG_B_IN_BIT];
    assign cl_in = cfg_r[CFG_CL_IN_BIT];

    assign first_port_pins_o = out_a_r;
    assign second_port_pins_o = out_b_r;
    assign third_port_pins_o = out_c_r;
    assign first_port_pins_oe_o = {PPI_W{!a_in}};
    assign second_port_pins_oe_o = {PPI_W{!b_in}};
    assign third_port_pins_oe_o = {{4{!cu_in}}, {4{!cl_in}}};

    ////////////////////////////////////////////////////////////////////////////
    // Read path; output halves of the third port read back their latch
    logic [PPI_W-1:0] c_view, rd_data_r, rd_data_nxt;
    logic rd_oe_r, rd_oe_nxt;
    logic [3:0] rd_hit;
    assign rd_hit = tgt_dec(psel_s);
    assign c_view = {cu_in ? pc_s[7:4] : out_c_r[7:4],
                     cl_in ? pc_s[3:0] : out_c_r[3:0]};

    always_comb begin
        rd_oe_nxt = !sel_n_s && !rd_n_s && !rd_hit[3];
        if (rd_hit[0]) begin
            rd_data_nxt = a_in ? in_a_r : out_a_r;
        end else if (rd_hit[1]) begin
            rd_data_nxt = b_in ? pb_s : out_b_r;
        end else if (rd_hit[2]) begin
            rd_data_nxt = c_view;
        end else begin
            rd_data_nxt = PORT_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_oe_r <= 1'b0;
            rd_data_r <= PORT_RESET;
        end else begin
            rd_oe_r <= rd_oe_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign host_data_bus_o = rd_data_r;
    assign host_data_bus_oe_o = rd_oe_r;
endmodule

// >>> sim/ppi_host_model.sv
// Host model: select, strobes, address and the resolved data bus
`timescale 1ns/1ps
module ppi_host_model
    import ppi_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic [PPI_W-1:0] dev_data_i, // Device bus drive
    input wire logic dev_oe_i, // Device bus enable
    output logic sel_n_o, // Select, active low
    output logic rd_n_o, // Read strobe, active low
    output logic wr_n_o, // Write strobe, active low
    output logic [1:0] addr_o, // Target select
    output logic [PPI_W-1:0] bus_o // Resolved bus level
);
    logic [PPI_W-1:0] drv;
    logic [PPI_W-1:0] last = '1;
    initial begin
        {sel_n_o, rd_n_o, wr_n_o, addr_o, drv} = '1;
    end
    // A released bus shows the inverse of its last value, never a stale match
    assign bus_o = !wr_n_o ? drv : (dev_oe_i ? dev_data_i : ~last);
    always @(posedge clk_i) begin
        if (dev_oe_i) last <= dev_data_i;
    end
    task automatic access(input logic s, w, input logic [1:0] a, input logic [7:0] d,
            output logic oe, output logic [7:0] q);
        @(posedge clk_i);
        #1 {addr_o, drv, sel_n_o, rd_n_o, wr_n_o} = {a, d, s, w, !w};
        repeat (5) @(posedge clk_i);
        // Sample once the edge has settled, then drop the strobes
        #1 {oe, q} = {dev_oe_i, bus_o};
        {rd_n_o, wr_n_o} = 2'h3;
        repeat (2) @(posedge clk_i);
        #1 sel_n_o = 1'b1;
        repeat (5) @(posedge clk_i);
    endtask
endmodule

// >>> sim/ppi_port_monitor.sv
// Concurrent checks on the host bus and pin drives of the I/O port
`timescale 1ns/1ps
module ppi_port_monitor
    import ppi_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic sys_rst_i, // Synchronous reset, active high
    input wire logic sel_n_i, // Device select, active low
    input wire logic rd_n_i, // Read strobe, active low
    input wire logic wr_n_i, // Write strobe, active low
    input wire logic [1:0] port_select_lines_i, // Target select
    input wire logic host_data_bus_oe_o, // Bus enable
    input wire logic [PPI_W-1:0] host_data_bus_o, // Bus drive value
    input wire logic [PPI_W-1:0] second_port_pins_i, // Second port levels
    input wire logic [PPI_W-1:0] third_port_pins_i, // Third port levels
    input wire logic [PPI_W-1:0] first_port_pins_o, // First port drive
    input wire logic [PPI_W-1:0] second_port_pins_o, // Second port drive
    input wire logic [PPI_W-1:0] third_port_pins_o, // Third port drive
    input wire logic [PPI_W-1:0] first_port_pins_oe_o, // First port enables
    input wire logic [PPI_W-1:0] second_port_pins_oe_o, // Second port enables
    input wire logic [PPI_W-1:0] third_port_pins_oe_o // Third port enables
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Strobes cross a two-stage sync, so each cause is held past that lag
    sequence s_rd(logic [1:0] a);
        (!sel_n_i && !rd_n_i && port_select_lines_i == a)[*5];
    endsequence
    property p_live(logic [1:0] a, logic [7:0] p, logic [7:0] en);
        (s_rd(a) and ($stable(p) && en == 8'h00)[*5]) |-> host_data_bus_o == p;
    endproperty
    a_bus_float: assert property ((sel_n_i || rd_n_i)[*5] |-> !host_data_bus_oe_o)
        else $error("bus driven while not read");
    a_no_cfg_read: assert property (s_rd(2'h3) |-> !host_data_bus_oe_o)
        else $error("configuration word driven on bus");
    a_read_drive: assert property (
        (!sel_n_i && !rd_n_i && port_select_lines_i != 2'h3)[*5] |-> host_data_bus_oe_o)
        else $error("port read not driven");
    a_reset_clear: assert property ($fell(sys_rst_i) |-> !host_data_bus_oe_o &&
        (first_port_pins_oe_o | second_port_pins_oe_o | third_port_pins_oe_o) == 8'h00)
        else $error("ports not inputs after reset");
    a_group_dirs: assert property (first_port_pins_oe_o inside {8'h00, 8'hff} &&
        second_port_pins_oe_o inside {8'h00, 8'hff} && third_port_pins_oe_o[7:4] inside
        {4'h0, 4'hf} && third_port_pins_oe_o[3:0] inside {4'h0, 4'hf})
        else $error("direction split wrong");
    a_latch_hold: assert property (wr_n_i[*8] |-> $stable({first_port_pins_o,
        second_port_pins_o, third_port_pins_o})) else $error("latch moved without write");
    a_third_live: assert property (
        p_live(2'h2, third_port_pins_i, third_port_pins_oe_o))
        else $error("third port read not live");
    a_second_live: assert property (
        p_live(2'h1, second_port_pins_i, second_port_pins_oe_o))
        else $error("second port read wrong");
endmodule

// >>> sim/ppi_port_tb.sv
// Self-checking bench for the programmable parallel I/O port
`timescale 1ns/1ps
module ppi_port_tb;
    import ppi_pkg::*;
    logic clk_i, sys_rst_i, sel_n, rd_n, wr_n, bus_oe, oe;
    logic [1:0] psl;
    logic [7:0] bus_i, bus_o, q, a_o, a_oe, b_o, b_oe, c_o, c_oe, a_pin, b_pin, c_pin;
    logic [7:0] ext_a = 8'h5a, ext_b = 8'hc3, ext_c = 8'h96;
    int n_mismatch = 0;
    int samples_checked = 0;
    assign a_pin = (a_o & a_oe) | (ext_a & ~a_oe);
    assign b_pin = (b_o & b_oe) | (ext_b & ~b_oe);
    assign c_pin = (c_o & c_oe) | (ext_c & ~c_oe);
    ppi_port ppi_port_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sel_n_i(sel_n),
        .rd_n_i(rd_n), .wr_n_i(wr_n), .port_select_lines_i(psl), .host_data_bus_i(bus_i),
        .host_data_bus_o(bus_o), .host_data_bus_oe_o(bus_oe), .first_port_pins_i(a_pin),
        .first_port_pins_o(a_o), .first_port_pins_oe_o(a_oe), .second_port_pins_i(b_pin),
        .second_port_pins_o(b_o), .second_port_pins_oe_o(b_oe), .third_port_pins_i(c_pin),
        .third_port_pins_o(c_o), .third_port_pins_oe_o(c_oe));
    ppi_host_model ppi_host_model_inst (.clk_i(clk_i), .dev_data_i(bus_o), .dev_oe_i(bus_oe),
        .sel_n_o(sel_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(psl), .bus_o(bus_i));
    task automatic check(input string what, input logic [7:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        ppi_host_model_inst.access(1'b0, 1'b1, a, d, oe, q);
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        ppi_host_model_inst.access(1'b0, 1'b0, a, 8'h00, oe, q);
        check("read enable", {7'h00, a != 2'h3}, {7'h00, oe});
        if (a != 2'h3) check("read data", exp, q);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        sys_rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        rd(2'h0, 8'h5a);
        rd(2'h1, 8'hc3);
        rd(2'h2, 8'h96);
        rd(2'h3, 8'h00);
        $display("test reset inputs done");
        wr(2'h3, 8'h80);
        wr(2'h0, 8'h55);
        wr(2'h1, 8'ha3);
        wr(2'h2, 8'h3c);
        check("first pins", 8'h55, a_pin);
        rd(2'h1, 8'ha3);
        wr(2'h3, 8'h0f);
        wr(2'h3, 8'h08);
        check("third pins", 8'hac, c_pin);
        ppi_host_model_inst.access(1'b1, 1'b1, 2'h0, 8'hff, oe, q);
        check("first pins", 8'h55, a_pin);
        $display("test outputs done");
        wr(2'h3, 8'h88);
        check("third enables", 8'h0f, c_oe);
        check("second enables", 8'hff, b_oe);
        check("first pins", 8'h00, a_pin);
        rd(2'h2, 8'h90);
        @(posedge clk_i);
        #1 sys_rst_i = 1'b1;
        @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        @(posedge clk_i);
        #1 check("first enables", 8'h00, a_oe);
        $display("test mode and reset done");
        report_and_stop;
    end
endmodule
bind ppi_port ppi_port_monitor ppi_port_monitor_inst (.*);
